// file: core/rfq_pkg.sv
// Constants for the queued receive (read-log) command interpreter.
// Assumes one clock domain shared with the link command layer and an AXI4-Lite register master.
// Behaviour
// - Opcode 65h marks the queued receive command family, and the device recognises it as such.
// - Subcommand value 1h selects read log by DMA; 0h and 2h to 1Fh are reserved.
// - The subcommand sits in bits 4 to 0 of the current feature field, and 01h there requests read log.
// - The high byte of the 16-bit log count comes from the previous feature field.
// - Log address bits 23:0 come from current sector number, cylinder low and cylinder high.
// - Log address bits 47:24 come from the previous copies of those fields, giving a 48-bit address.
// - Successful completion of outstanding commands is reported by a set device bits frame with its interrupt bit set.
// - That frame carries one active bit per tag finished since the last notice, so several may share a frame.
// - An error found before busy is cleared for a received command is reported by a register device-to-host frame.
// - Parameter use, acceptance, completion and error reporting follow the chosen subcommand, not the family.
package rfq_pkg;

	localparam logic [7:0]  CMD_RECV_QUEUED   = 8'h65;
	localparam logic [4:0]  SUBCMD_READ_LOG   = 5'h01;
	localparam int          SUBCMD_MSB        = 4;
	localparam int          TAG_LSB           = 3;
	localparam int          TAG_W             = 5;
	localparam int          NUM_TAGS          = 32;

	// Ata status and error bit positions
	localparam int          STS_ERR_BIT       = 0;
	localparam int          STS_RDY_BIT       = 6;
	localparam int          STS_BSY_BIT       = 7;
	localparam int          ERR_ABT_BIT       = 2;

	// Register byte addresses
	localparam logic [7:0]  ADDR_CTRL         = 8'h00;
	localparam logic [7:0]  ADDR_IRQ_STATUS   = 8'h04;
	localparam logic [7:0]  ADDR_IRQ_MASK     = 8'h08;
	localparam logic [7:0]  ADDR_OUTSTANDING  = 8'h0C;
	localparam logic [7:0]  ADDR_LAST_CMD     = 8'h10;
	localparam logic [7:0]  ADDR_LAST_LBA_LO  = 8'h14;
	localparam logic [7:0]  ADDR_LAST_LBA_HI  = 8'h18;
	localparam logic [7:0]  ADDR_ABORTS       = 8'h1C;

	// Control fields
	localparam int          CTRL_QUEUE_EN_BIT = 0;
	localparam int          CTRL_DEPTH_LSB    = 8;
	localparam logic [31:0] CTRL_RESET        = 32'h0000_1F01;

	// Interrupt status and mask bits
	localparam int          IRQ_ACCEPT_BIT    = 0;
	localparam int          IRQ_ABORT_BIT     = 1;
	localparam int          IRQ_SDB_BIT       = 2;
	localparam int          IRQ_W             = 3;
	localparam logic [2:0]  IRQ_MASK_RESET    = 3'h0;

	// Last command fields
	localparam int          LAST_SUBCMD_LSB   = 0;
	localparam int          LAST_TAG_LSB      = 8;
	localparam int          LAST_COUNT_LSB    = 16;

	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CHECK,
		ST_REG_FIS
	} cmd_state_t;

endpackage

// file: core/rfq_log_cmd.sv
// Queued receive command decode, tag bookkeeping and completion frame generation.
// Assumes command blocks and completions arrive from same-clock link logic and the
// register master follows AXI4-Lite; the log data mover sits outside.
`timescale 1ns/10ps
module rfq_log_cmd
	import rfq_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              i_clk,
	input  wire logic              i_reset_n,
	input  wire logic              i_ce,
	// Command block from the link command layer
	input  wire logic              i_cmd_valid,
	input  wire logic [7:0]        i_command,
	input  wire logic [7:0]        i_feature_cur,
	input  wire logic [7:0]        i_feature_prev,
	input  wire logic [7:0]        i_count_cur,
	input  wire logic [7:0]        i_count_prev,
	input  wire logic [7:0]        i_sector_cur,
	input  wire logic [7:0]        i_sector_prev,
	input  wire logic [7:0]        i_cyl_low_cur,
	input  wire logic [7:0]        i_cyl_low_prev,
	input  wire logic [7:0]        i_cyl_high_cur,
	input  wire logic [7:0]        i_cyl_high_prev,
	output logic                   o_cmd_ready,
	output logic                   o_busy,
	// Read log request to the data mover
	output logic                   o_log_valid,
	output logic [TAG_W-1:0]       o_log_tag,
	output logic [15:0]            o_log_count,
	output logic [47:0]            o_log_lba,
	// Completion from the data mover
	input  wire logic              i_done_valid,
	input  wire logic [TAG_W-1:0]  i_done_tag,
	// Set device bits frame
	output logic                   o_sdb_valid,
	output logic [NUM_TAGS-1:0]    o_sdb_act,
	output logic                   o_sdb_irq,
	output logic [7:0]             o_sdb_status,
	output logic [7:0]             o_sdb_error,
	input  wire logic              i_sdb_ready,
	// Register device-to-host frame
	output logic                   o_rdh_valid,
	output logic [7:0]             o_rdh_status,
	output logic [7:0]             o_rdh_error,
	input  wire logic              i_rdh_ready,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   o_irq
);

	cmd_state_t          state_q;
	logic [TAG_W-1:0]    tag_q;
	logic [4:0]          subcmd_q;
	logic [15:0]         count_q;
	logic [47:0]         lba_q;
	logic [NUM_TAGS-1:0] outstanding_q;
	logic [NUM_TAGS-1:0] done_q;
	logic [31:0]         ctrl_q;
	logic [IRQ_W-1:0]    irq_status_q;
	logic [IRQ_W-1:0]    irq_mask_q;
	logic [15:0]         aborts_q;
	logic [ADDR_W-1:0]   awaddr_q;
	logic                aw_full_q;
	logic [31:0]         wdata_q;
	logic [3:0]          wstrb_q;
	logic                w_full_q;

	logic                cmd_take;
	logic                cmd_error;
	logic                accept_ev;
	logic                abort_ev;
	logic                sdb_load;
	logic                done_hit;
	logic                wr_do;
	logic                wr_hit;
	logic [NUM_TAGS-1:0] done_set;
	logic [7:0]          wr_addr;
	logic [7:0]          rd_addr;
	logic [TAG_W-1:0]    depth_last;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Only the receive family is taken; other opcodes belong to other handlers
	assign cmd_take   = i_ce && o_cmd_ready && i_cmd_valid && (i_command == CMD_RECV_QUEUED);
	assign depth_last = ctrl_q[CTRL_DEPTH_LSB +: TAG_W];
	// Checks are chosen per subcommand; only read log defines any
	assign cmd_error  = (subcmd_q != SUBCMD_READ_LOG)
	                  || !ctrl_q[CTRL_QUEUE_EN_BIT]
	                  || (tag_q > depth_last)
	                  || outstanding_q[tag_q];
	assign accept_ev  = i_ce && (state_q == ST_CHECK) && !cmd_error;
	assign abort_ev   = i_ce && (state_q == ST_CHECK) && cmd_error;
	assign done_hit   = i_done_valid && outstanding_q[i_done_tag];
	assign done_set   = done_hit ? (NUM_TAGS'(1) << i_done_tag) : '0;
	assign sdb_load   = i_ce && (|done_q) && (!o_sdb_valid || i_sdb_ready);
	assign wr_do      = i_ce && aw_full_q && w_full_q && !s_axi_bvalid;
	assign wr_addr    = 8'(awaddr_q);
	assign rd_addr    = 8'(s_axi_araddr);
	assign wr_hit     = (wr_addr == ADDR_CTRL) || (wr_addr == ADDR_IRQ_STATUS) || (wr_addr == ADDR_IRQ_MASK);

	// Command sequencing
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q     <= ST_IDLE;
			o_cmd_ready <= 1'b0;
			o_busy      <= 1'b0;
		end else if (i_ce) begin
			case (state_q)
				ST_IDLE: begin
					o_cmd_ready <= !cmd_take;
					if (cmd_take) begin
						state_q <= ST_CHECK;
						o_busy  <= 1'b1;
					end
				end
				ST_CHECK: begin
					if (cmd_error) begin
						state_q <= ST_REG_FIS;
					end else begin
						state_q     <= ST_IDLE;
						o_busy      <= 1'b0;
						o_cmd_ready <= 1'b1;
					end
				end
				ST_REG_FIS: begin
					if (o_rdh_valid && i_rdh_ready) begin
						state_q     <= ST_IDLE;
						o_busy      <= 1'b0;
						o_cmd_ready <= 1'b1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Field capture
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tag_q    <= '0;
			subcmd_q <= '0;
			count_q  <= '0;
			lba_q    <= '0;
		end else if (cmd_take) begin
			subcmd_q <= i_feature_cur[SUBCMD_MSB:0];
			tag_q    <= i_count_cur[TAG_LSB +: TAG_W];
			count_q  <= {i_feature_prev, i_count_prev};
			lba_q    <= {i_cyl_high_prev, i_cyl_low_prev, i_sector_prev,
			             i_cyl_high_cur, i_cyl_low_cur, i_sector_cur};
		end
	end

	// Request to the data mover, one cycle per accepted command
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_log_valid <= 1'b0;
			o_log_tag   <= '0;
			o_log_count <= '0;
			o_log_lba   <= '0;
		end else if (i_ce) begin
			o_log_valid <= accept_ev;
			if (accept_ev) begin
				o_log_tag   <= tag_q;
				o_log_count <= count_q;
				o_log_lba   <= lba_q;
			end
		end
	end

	// Error frame before busy is released
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdh_valid  <= 1'b0;
			o_rdh_status <= '0;
			o_rdh_error  <= '0;
		end else if (i_ce) begin
			if (abort_ev) begin
				o_rdh_valid                <= 1'b1;
				o_rdh_status               <= '0;
				o_rdh_status[STS_ERR_BIT]  <= 1'b1;
				o_rdh_status[STS_RDY_BIT]  <= 1'b1;
				o_rdh_error                <= '0;
				o_rdh_error[ERR_ABT_BIT]   <= 1'b1;
			end else if (o_rdh_valid && i_rdh_ready) begin
				o_rdh_valid <= 1'b0;
			end
		end
	end

	// Outstanding tags and completions gathered since the last notice
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			outstanding_q <= '0;
			done_q        <= '0;
		end else if (i_ce) begin
			outstanding_q <= (outstanding_q & ~done_set) | (accept_ev ? (NUM_TAGS'(1) << tag_q) : '0);
			// A completion landing on the load cycle stays for the next frame
			done_q        <= (sdb_load ? '0 : done_q) | done_set;
		end
	end

	// Completion frame; holds until the link takes it
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_sdb_valid  <= 1'b0;
			o_sdb_act    <= '0;
			o_sdb_irq    <= 1'b0;
			o_sdb_status <= '0;
			o_sdb_error  <= '0;
		end else if (i_ce) begin
			if (sdb_load) begin
				o_sdb_valid               <= 1'b1;
				o_sdb_act                 <= done_q;
				o_sdb_irq                 <= 1'b1;
				o_sdb_status              <= '0;
				o_sdb_status[STS_RDY_BIT] <= 1'b1;
				o_sdb_error               <= '0;
			end else if (o_sdb_valid && i_sdb_ready) begin
				o_sdb_valid <= 1'b0;
			end
		end
	end

	// Write channels, address and data taken in either order
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			aw_full_q     <= 1'b0;
			w_full_q      <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= '0;
			wstrb_q       <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else if (i_ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q     <= 1'b1;
				awaddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q     <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_do) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_full_q     <= 1'b0;
				w_full_q      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Software control: queueing enable and highest legal tag
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_q     <= CTRL_RESET;
			irq_mask_q <= IRQ_MASK_RESET;
		end else if (wr_do) begin
			if (wr_addr == ADDR_CTRL) begin
				ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
			end
			if (wr_addr == ADDR_IRQ_MASK && wstrb_q[0]) begin
				irq_mask_q <= wdata_q[IRQ_W-1:0];
			end
		end
	end

	// Sticky events; a new event wins over a write-one clear in the same cycle
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_status_q <= '0;
			aborts_q     <= '0;
		end else if (i_ce) begin
			irq_status_q <= (irq_status_q
			                 & ~((wr_do && wr_addr == ADDR_IRQ_STATUS && wstrb_q[0]) ? wdata_q[IRQ_W-1:0] : '0))
			                | {sdb_load, abort_ev, accept_ev};
			if (abort_ev) begin
				aborts_q <= aborts_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_irq <= 1'b0;
		end else if (i_ce) begin
			o_irq <= |(irq_status_q & irq_mask_q);
		end
	end

	// Read channel, answer one cycle after the address is taken
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (i_ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= RESP_OKAY;
				case (rd_addr)
					ADDR_CTRL:        s_axi_rdata <= ctrl_q;
					ADDR_IRQ_STATUS:  s_axi_rdata <= 32'(irq_status_q);
					ADDR_IRQ_MASK:    s_axi_rdata <= 32'(irq_mask_q);
					ADDR_OUTSTANDING: s_axi_rdata <= outstanding_q;
					ADDR_LAST_CMD: begin
						s_axi_rdata <= '0;
						s_axi_rdata[LAST_SUBCMD_LSB +: 5] <= subcmd_q;
						s_axi_rdata[LAST_TAG_LSB +: TAG_W] <= tag_q;
						s_axi_rdata[LAST_COUNT_LSB +: 16]  <= count_q;
					end
					ADDR_LAST_LBA_LO: s_axi_rdata <= lba_q[31:0];
					ADDR_LAST_LBA_HI: s_axi_rdata <= {16'h0000, lba_q[47:32]};
					ADDR_ABORTS:      s_axi_rdata <= {16'h0000, aborts_q};
					default: begin
						s_axi_rdata <= '0;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule

// file: test/rfq_log_cmd_checker.sv
// Concurrent checks on command take, log request fields and device frames.
// Assumes the bench holds i_ce high; sees only the top module's ports.
`timescale 1ns/10ps
module rfq_log_cmd_checker
	import rfq_pkg::*;
(
	input wire logic              i_clk,
	input wire logic              i_reset_n,
	input wire logic              i_ce,
	input wire logic              i_cmd_valid,
	input wire logic [7:0]        i_command,
	input wire logic [7:0]        i_feature_cur,
	input wire logic [7:0]        i_feature_prev,
	input wire logic [7:0]        i_count_cur,
	input wire logic [7:0]        i_count_prev,
	input wire logic [7:0]        i_sector_cur,
	input wire logic [7:0]        i_sector_prev,
	input wire logic [7:0]        i_cyl_low_cur,
	input wire logic [7:0]        i_cyl_low_prev,
	input wire logic [7:0]        i_cyl_high_cur,
	input wire logic [7:0]        i_cyl_high_prev,
	input wire logic              o_cmd_ready,
	input wire logic              o_busy,
	input wire logic              o_log_valid,
	input wire logic [TAG_W-1:0]  o_log_tag,
	input wire logic [15:0]       o_log_count,
	input wire logic [47:0]       o_log_lba,
	input wire logic              o_sdb_valid,
	input wire logic [NUM_TAGS-1:0] o_sdb_act,
	input wire logic              o_sdb_irq,
	input wire logic [7:0]        o_sdb_status,
	input wire logic [7:0]        o_sdb_error,
	input wire logic              i_sdb_ready,
	input wire logic              o_rdh_valid,
	input wire logic [7:0]        o_rdh_status,
	input wire logic [7:0]        o_rdh_error,
	input wire logic              i_rdh_ready
);
	logic        take;
	logic [4:0]  sub_w;
	logic [4:0]  tag_w;
	logic [15:0] cnt_w;
	logic [47:0] lba_w;
	assign take  = i_ce && o_cmd_ready && i_cmd_valid && i_command == CMD_RECV_QUEUED;
	assign sub_w = i_feature_cur[4:0];
	assign tag_w = i_count_cur[7:3];
	assign cnt_w = {i_feature_prev, i_count_prev};
	assign lba_w = {i_cyl_high_prev, i_cyl_low_prev, i_sector_prev, i_cyl_high_cur, i_cyl_low_cur, i_sector_cur};

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	sequence s_accept;
		##2 o_log_valid && !o_busy && o_cmd_ready;
	endsequence
	sequence s_refuse;
		##2 o_rdh_valid && !o_log_valid;
	endsequence

	a_take_busy: assert property (take |=> o_busy && !o_cmd_ready) else $error("busy not raised on take");
	a_other_ignored: assert property (i_ce && o_cmd_ready && i_cmd_valid && i_command != CMD_RECV_QUEUED
		|=> o_cmd_ready && !o_busy) else $error("foreign opcode taken");
	a_reserved_abort: assert property (take && sub_w != SUBCMD_READ_LOG |-> s_refuse)
		else $error("reserved subcommand not aborted");
	a_sub_outcome: assert property (take && sub_w == SUBCMD_READ_LOG |-> s_accept or s_refuse)
		else $error("read log command without outcome");
	a_sub_select: assert property (o_log_valid |-> $past(sub_w, 2) == SUBCMD_READ_LOG)
		else $error("log request from wrong subcommand");
	a_count_tag: assert property (o_log_valid |-> o_log_count == $past(cnt_w, 2) && o_log_tag == $past(tag_w, 2))
		else $error("log count or tag wrong");
	a_lba_form: assert property (o_log_valid |-> o_log_lba == $past(lba_w, 2)) else $error("log address wrong");
	a_sdb_form: assert property (o_sdb_valid |-> o_sdb_irq && o_sdb_act != '0 && o_sdb_error == 8'h00
		&& !o_sdb_status[STS_ERR_BIT]) else $error("completion frame malformed");
	a_sdb_hold: assert property (o_sdb_valid && !i_sdb_ready |=> o_sdb_valid && $stable(o_sdb_act))
		else $error("completion frame changed before taken");
	a_rdh_form: assert property (o_rdh_valid |-> o_busy && o_rdh_status[STS_ERR_BIT] && !o_rdh_status[STS_BSY_BIT]
		&& o_rdh_error[ERR_ABT_BIT]) else $error("error frame malformed");
	a_rdh_release: assert property (o_rdh_valid && i_rdh_ready |=> !o_rdh_valid ##[0:1] (o_cmd_ready && !o_busy))
		else $error("idle not restored after error frame");
endmodule

bind rfq_log_cmd rfq_log_cmd_checker u_chk (.*);

// file: test/rfq_host_model.sv
// Host side model: issues command blocks and takes device frames after a stall.
// Assumes the bench pulses i_go for one cycle while the device is idle.
`timescale 1ns/10ps
module rfq_host_model
	import rfq_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_go,
	input  wire logic [7:0]  i_op,
	input  wire logic [4:0]  i_sub,
	input  wire logic [4:0]  i_tag,
	input  wire logic [15:0] i_cnt,
	input  wire logic [47:0] i_lba,
	input  wire logic [3:0]  i_stall,
	input  wire logic        i_cmd_ready,
	input  wire logic        i_frame_valid,
	output logic             o_cmd_valid,
	output logic [7:0]       o_command,
	output logic [7:0]       o_feature_cur,
	output logic [7:0]       o_feature_prev,
	output logic [7:0]       o_count_cur,
	output logic [7:0]       o_count_prev,
	output logic [7:0]       o_sector_cur,
	output logic [7:0]       o_sector_prev,
	output logic [7:0]       o_cyl_low_cur,
	output logic [7:0]       o_cyl_low_prev,
	output logic [7:0]       o_cyl_high_cur,
	output logic [7:0]       o_cyl_high_prev,
	output logic             o_frame_ready
);
	logic [87:0] blk_q;
	logic [2:0]  hold_q;
	logic [3:0]  wait_q;
	assign {o_command, o_feature_cur, o_feature_prev, o_count_cur, o_count_prev, o_sector_cur,
		o_sector_prev, o_cyl_low_cur, o_cyl_low_prev, o_cyl_high_cur, o_cyl_high_prev} = blk_q;

	// Foreign opcodes are never taken, so the host gives up after eight cycles
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_cmd_valid <= 1'b0;
			hold_q      <= 3'h0;
			blk_q       <= '0;
		end else if (i_go) begin
			o_cmd_valid <= 1'b1;
			hold_q      <= 3'h0;
			blk_q       <= {i_op, 3'h5, i_sub, i_cnt[15:8], i_tag, 3'h6, i_cnt[7:0], i_lba[7:0], i_lba[31:24],
				i_lba[15:8], i_lba[39:32], i_lba[23:16], i_lba[47:40]};
		end else if (o_cmd_valid && ((i_cmd_ready && o_command == CMD_RECV_QUEUED) || hold_q == 3'h7)) begin
			o_cmd_valid <= 1'b0;
			// Released lines flip so a stale block cannot pass as held
			blk_q       <= ~blk_q;
		end else if (o_cmd_valid) begin
			hold_q <= hold_q + 3'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_frame_ready <= 1'b0;
			wait_q        <= 4'h0;
		end else if (i_frame_valid && !o_frame_ready) begin
			o_frame_ready <= (wait_q == i_stall);
			wait_q        <= wait_q + 4'h1;
		end else begin
			o_frame_ready <= 1'b0;
			wait_q        <= 4'h0;
		end
	end
endmodule

// file: test/testbench.sv
// Self-checking bench: commands through the host model, registers over AXI4-Lite.
// Assumes the hand-over timing of the design; clock enable stays high throughout.
`timescale 1ns/10ps
module testbench;
	import rfq_pkg::*;
	logic        i_clk = 1'b0, i_reset_n, i_ce = 1'b1, go = 1'b0, i_done_valid = 1'b0;
	logic        i_cmd_valid, o_cmd_ready, o_busy, o_log_valid, o_sdb_valid, o_sdb_irq, i_sdb_ready;
	logic        o_rdh_valid, i_rdh_ready, o_irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0]  i_command, i_feature_cur, i_feature_prev, i_count_cur, i_count_prev, i_sector_cur;
	logic [7:0]  i_sector_prev, i_cyl_low_cur, i_cyl_low_prev, i_cyl_high_cur, i_cyl_high_prev;
	logic [7:0]  o_sdb_status, o_sdb_error, o_rdh_status, o_rdh_error, op = 8'h00;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [4:0]  o_log_tag, i_done_tag = 5'h00, sub = 5'h00, tag = 5'h00;
	logic [4:0]  tl [3] = '{5'h03, 5'h00, 5'h1F};
	logic [15:0] o_log_count, cnt = 16'h0000;
	logic [47:0] o_log_lba, lba = 48'h0;
	logic [31:0] o_sdb_act, s_axi_rdata, s_axi_wdata = 32'h0, act_or = 32'h0, act_last = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF, stall = 4'h0;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          err_total = 0, checks = 0, cyc = 0, log_n = 0, sdb_n = 0, rdh_n = 0;

	always #5 i_clk = ~i_clk;
	rfq_log_cmd dut (.*);
	rfq_host_model host (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_go(go), .i_op(op), .i_sub(sub), .i_tag(tag),
		.i_cnt(cnt), .i_lba(lba), .i_stall(stall), .i_cmd_ready(o_cmd_ready),
		.i_frame_valid(o_sdb_valid || o_rdh_valid), .o_cmd_valid(i_cmd_valid), .o_command(i_command),
		.o_feature_cur(i_feature_cur), .o_feature_prev(i_feature_prev), .o_count_cur(i_count_cur),
		.o_count_prev(i_count_prev), .o_sector_cur(i_sector_cur), .o_sector_prev(i_sector_prev),
		.o_cyl_low_cur(i_cyl_low_cur), .o_cyl_low_prev(i_cyl_low_prev), .o_cyl_high_cur(i_cyl_high_cur),
		.o_cyl_high_prev(i_cyl_high_prev), .o_frame_ready(i_sdb_ready));
	assign i_rdh_ready = i_sdb_ready;

	task chk(input string name, input logic [63:0] e, input logic [63:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %0h seen %0h", name, e, g);
		end
	endtask

	task conclude;
		if (err_total == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Handshakes sampled at the falling edge, where registered readies are settled
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ha, hw, hb;
		logic [1:0] r;
		@(posedge i_clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		hb = 1'b0;
		while (!hb) begin
			@(negedge i_clk);
			ha = s_axi_awready;
			hw = s_axi_wready;
			hb = s_axi_bvalid;
			r  = s_axi_bresp;
			@(posedge i_clk);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		chk("bresp", er, r);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ha, h;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge i_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		h = 1'b0;
		while (!h) begin
			@(negedge i_clk);
			ha = s_axi_arready;
			h  = s_axi_rvalid;
			d  = s_axi_rdata;
			r  = s_axi_rresp;
			@(posedge i_clk);
			if (ha) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk("rdata", e, d);
		chk("rresp", er, r);
	endtask

	task cmd(input logic [7:0] o, input logic [4:0] s, input logic [4:0] t);
		@(posedge i_clk);
		op  <= o;
		sub <= s;
		tag <= t;
		go  <= 1'b1;
		@(posedge i_clk);
		go <= 1'b0;
		do @(negedge i_clk); while (i_cmd_valid || !o_cmd_ready);
		repeat (2) @(negedge i_clk);
	endtask

	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			conclude();
		end
		if (o_log_valid) begin
			log_n++;
			chk("log_tag", tag, o_log_tag);
			chk("log_count", cnt, o_log_count);
			chk("log_lba", lba, o_log_lba);
		end
		if (o_sdb_valid && i_sdb_ready) begin
			sdb_n++;
			act_or   = act_or | o_sdb_act;
			act_last = o_sdb_act;
			chk("sdb_frame", {8'h40, 8'h00, 1'b1}, {o_sdb_status, o_sdb_error, o_sdb_irq});
		end
		if (o_rdh_valid && i_rdh_ready) begin
			rdh_n++;
			chk("rdh_frame", 16'h4104, {o_rdh_status, o_rdh_error});
		end
	end

	initial begin
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_reset_n <= 1'b1;
		rd(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
		rd(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
		rd(8'h20, 32'h0, RESP_SLVERR);
		wr(ADDR_OUTSTANDING, 32'hF, RESP_SLVERR);
		cnt <= 16'h1234;
		lba <= 48'hABCD_EF01_2345;
		cmd(CMD_RECV_QUEUED, SUBCMD_READ_LOG, 5'h03);
		chk("log_n", 1, log_n);
		rd(ADDR_OUTSTANDING, 32'h0000_0008, RESP_OKAY);
		rd(ADDR_LAST_CMD, 32'h1234_0301, RESP_OKAY);
		rd(ADDR_LAST_LBA_LO, 32'hEF01_2345, RESP_OKAY);
		rd(ADDR_LAST_LBA_HI, 32'h0000_ABCD, RESP_OKAY);
		chk("irq", 0, o_irq);
		wr(ADDR_IRQ_MASK, 32'h7, RESP_OKAY);
		@(negedge i_clk);
		chk("irq", 1, o_irq);
		rd(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
		wr(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
		rd(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
		@(negedge i_clk);
		chk("irq", 0, o_irq);
		for (int s = 0; s < 32; s++) if (s != 1) cmd(CMD_RECV_QUEUED, s[4:0], 5'h05);
		chk("rdh_n", 31, rdh_n);
		rd(ADDR_ABORTS, 32'h0000_001F, RESP_OKAY);
		cmd(8'h64, SUBCMD_READ_LOG, 5'h06);
		cmd(8'h25, SUBCMD_READ_LOG, 5'h07);
		cmd(CMD_RECV_QUEUED, SUBCMD_READ_LOG, 5'h03);
		// Queueing off, then highest legal tag four (five tags) with tag six
		wr(ADDR_CTRL, 32'h0000_0400, RESP_OKAY);
		cmd(CMD_RECV_QUEUED, SUBCMD_READ_LOG, 5'h02);
		wr(ADDR_CTRL, 32'h0000_0401, RESP_OKAY);
		rd(ADDR_CTRL, 32'h0000_0401, RESP_OKAY);
		cmd(CMD_RECV_QUEUED, SUBCMD_READ_LOG, 5'h06);
		wr(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
		chk("rdh_n", 34, rdh_n);
		cnt <= 16'hFFFF;
		lba <= 48'h8000_0000_0001;
		cmd(CMD_RECV_QUEUED, SUBCMD_READ_LOG, 5'h00);
		cmd(CMD_RECV_QUEUED, SUBCMD_READ_LOG, 5'h1F);
		chk("log_n", 3, log_n);
		rd(ADDR_OUTSTANDING, 32'h8000_0009, RESP_OKAY);
		stall <= 4'h5;
		for (int k = 0; k < 3; k++) begin
			@(posedge i_clk);
			i_done_valid <= 1'b1;
			i_done_tag   <= tl[k];
		end
		@(posedge i_clk);
		i_done_valid <= 1'b0;
		repeat (30) @(negedge i_clk);
		chk("sdb_n", 2, sdb_n);
		chk("act_last", 32'h8000_0001, act_last);
		chk("act_or", 32'h8000_0009, act_or);
		@(posedge i_clk);
		i_done_valid <= 1'b1;
		i_done_tag   <= 5'h09;
		@(posedge i_clk);
		i_done_valid <= 1'b0;
		repeat (20) @(negedge i_clk);
		chk("sdb_n", 2, sdb_n);
		rd(ADDR_OUTSTANDING, 32'h0, RESP_OKAY);
		rd(ADDR_IRQ_STATUS, 32'h7, RESP_OKAY);
		wr(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
		@(negedge i_clk);
		chk("irq", 0, o_irq);
		conclude();
	end
endmodule
